// >>> ccce_core.sv
/*
 * Core end: decodes and executes coprocessor data op, clear exclusive,
 * leading zero count and compare negative with immediate.
 * Assumes the core register file supplies the operand value with each
 * issue and takes the write-back; coprocessor on the same clock.
 */
`timescale 1ns/1ps
`include "ccce_consts.svh"

module ccce_core #(
    parameter int COP_TIMEOUT = `CCCE_COP_TIMEOUT
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_ce,
    input  wire logic        i_issue,
    input  wire logic [31:0] i_instr,
    input  wire logic        i_cond_pass,
    input  wire logic [31:0] i_operand,
    input  wire logic        i_excl_mark,
    ccce_cop_if.core         cop,
    output logic             o_ready,
    output logic             o_done,
    output logic             o_wb_en,
    output logic [3:0]       o_wb_index,
    output logic [31:0]      o_wb_data,
    output logic [3:0]       o_flags,
    output logic             o_excl_open,
    output logic             o_usage_fault_a,
    output logic             o_undef
);

    localparam int CW = $clog2(COP_TIMEOUT + 1);

    ccce_pkg::ccce_state_t state;
    ccce_pkg::ccce_flags_t next_flags;

    logic [CW-1:0] wait_cnt;
    logic          take;
    logic          is_cop;
    logic          is_xclr;
    logic          is_lzc;
    logic          is_cneg;
    logic          lzc_bad;
    logic          cneg_bad;
    logic          wait_over;
    logic [3:0]    src_reg;
    logic [3:0]    src_reg2;
    logic [3:0]    dst_reg;
    logic [3:0]    first_operand_register;
    logic [11:0]   imm12;
    logic [31:0]   imm32;
    logic [32:0]   sum;
    logic [5:0]    zero_count;

    // expand 12-bit immediate into 32-bit constant
    function automatic logic [31:0] modified_immediate_expand(
        input logic [11:0] f
    );
        logic [31:0] unrot;
        logic [4:0]  rot;
        unrot = {24'h00_0000, 1'b1, f[6:0]};
        rot   = f[11:7];
        if (f[11:10] == 2'b00) begin
            unique case (f[9:8])
                2'b00: modified_immediate_expand = {24'h00_0000, f[7:0]};
                2'b01: modified_immediate_expand =
                    {8'h00, f[7:0], 8'h00, f[7:0]};
                2'b10: modified_immediate_expand =
                    {f[7:0], 8'h00, f[7:0], 8'h00};
                2'b11: modified_immediate_expand =
                    {f[7:0], f[7:0], f[7:0], f[7:0]};
            endcase
        end else begin
            modified_immediate_expand = (unrot >> rot)
                | (unrot << (6'h20 - {1'b0, rot}));
        end
    endfunction

    // zeros above the most significant one, 32 for zero input
    function automatic logic [5:0] count_leading(input logic [31:0] v);
        logic found;
        count_leading = `CCCE_ZERO_COUNT;
        found = 1'b0;
        for (int k = 31; k >= 0; k--) begin
            if (v[k] && !found) begin
                count_leading = 6'(31 - k);
                found = 1'b1;
            end
        end
    endfunction

    assign take = i_issue && (state == ccce_pkg::ST_IDLE);

    // recognition by fixed bits only
    assign is_cop   = (i_instr & `CCCE_COPOP_MASK)
        == `CCCE_COPOP_MATCH;
    assign is_xclr  = (i_instr & `CCCE_XCLR_MASK)
        == `CCCE_XCLR_MATCH;
    assign is_lzc   = (i_instr & `CCCE_LZCNT_MASK) == `CCCE_LZCNT_MATCH;
    assign is_cneg  = (i_instr & `CCCE_CNEG_MASK) == `CCCE_CNEG_MATCH;

    assign src_reg  = i_instr[`CCCE_SRC_LSB +: 4];
    assign src_reg2 = i_instr[`CCCE_SRC2_LSB +: 4];
    assign dst_reg  = i_instr[`CCCE_RD_LSB +: 4];
    assign first_operand_register = i_instr[`CCCE_OPND_LSB +: 4];

    assign lzc_bad = (src_reg != src_reg2)
        || (dst_reg == `CCCE_REG_SP) || (dst_reg == `CCCE_REG_PC)
        || (src_reg == `CCCE_REG_SP) || (src_reg == `CCCE_REG_PC);
    // stack pointer passes, only register 15 refused
    assign cneg_bad =
        (first_operand_register == `CCCE_REG_PC);

    assign imm12 = {i_instr[`CCCE_IBIT], i_instr[`CCCE_IMM3_LSB +: 3],
                    i_instr[`CCCE_IMM8_LSB +: 8]};
    assign imm32 = modified_immediate_expand(imm12);
    assign sum   = {1'b0, i_operand} + {1'b0, imm32};
    assign zero_count = count_leading(i_operand);

    always_comb begin
        next_flags.n = sum[31];
        next_flags.z = (sum[31:0] == 32'h0000_0000);
        next_flags.c = sum[32];
        next_flags.v = (i_operand[31] == imm32[31])
            && (sum[31] != i_operand[31]);
    end

    assign wait_over = (wait_cnt == CW'(COP_TIMEOUT - 1));

    // coprocessor offer and wait
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state      <= ccce_pkg::ST_IDLE;
            cop.req    <= 1'b0;
            cop.instr  <= 32'h0000_0000;
            cop.cp_num <= 4'h0;
            cop.alt    <= 1'b0;
            wait_cnt   <= '0;
            o_ready    <= 1'b1;
        end else if (i_ce) begin
            unique case (state)
                ccce_pkg::ST_IDLE: begin
                    if (take && is_cop && i_cond_pass) begin
                        state      <= ccce_pkg::ST_COP;
                        cop.req    <= 1'b1;
                        cop.instr  <= i_instr;
                        cop.cp_num <= i_instr[`CCCE_CP_LSB +: 4];
                        cop.alt    <= i_instr[`CCCE_COPOP_ALT_BIT];
                        wait_cnt   <= '0;
                        o_ready    <= 1'b0;
                    end
                end
                ccce_pkg::ST_COP: begin
                    if (cop.ack || wait_over) begin
                        state   <= ccce_pkg::ST_IDLE;
                        cop.req <= 1'b0;
                        o_ready <= 1'b1;
                    end else begin
                        wait_cnt <= wait_cnt + CW'(1);
                    end
                end
            endcase
        end
    end

    // completion, write-back and fault pulses
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_done          <= 1'b0;
            o_wb_en         <= 1'b0;
            o_wb_index      <= 4'h0;
            o_wb_data       <= 32'h0000_0000;
            o_usage_fault_a <= 1'b0;
            o_undef         <= 1'b0;
        end else if (i_ce) begin
            o_done          <= 1'b0;
            o_wb_en         <= 1'b0;
            o_usage_fault_a <= 1'b0;
            o_undef         <= 1'b0;
            if (state == ccce_pkg::ST_IDLE && take) begin
                if (!(is_cop && i_cond_pass)) begin
                    o_done <= 1'b1;
                end
                if ((is_lzc && lzc_bad) || (is_cneg && cneg_bad)
                    || !(is_cop || is_xclr || is_lzc || is_cneg)) begin
                    o_undef <= 1'b1;
                end else if (is_lzc && i_cond_pass) begin
                    o_wb_en    <= 1'b1;
                    o_wb_index <= dst_reg;
                    o_wb_data  <= {26'h000_0000, zero_count};
                end
            end else if (state == ccce_pkg::ST_COP) begin
                if (cop.ack) begin
                    o_done          <= 1'b1;
                    o_usage_fault_a <= !cop.accept;
                end else if (wait_over) begin
                    o_done          <= 1'b1;
                    o_usage_fault_a <= 1'b1;
                end
            end
        end
    end

    // condition flags, compare negative only
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_flags <= `CCCE_FLAGS_RST;
        end else if (i_ce) begin
            if (take && is_cneg && !cneg_bad && i_cond_pass) begin
                o_flags <= next_flags;
            end
        end
    end

    // local exclusive monitor, a new mark wins over a clear
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_excl_open <= 1'b0;
        end else if (i_ce) begin
            if (i_excl_mark) begin
                o_excl_open <= 1'b1;
            end else if (take && is_xclr && i_cond_pass) begin
                o_excl_open <= 1'b0;
            end
        end
    end

endmodule // ccce_core

// >>> ccce_consts.svh
/*
 * Encodings, field positions, reset values and the coprocessor wait limit
 * for the instruction execute block and its coprocessor.
 * Assumes 32-bit instruction words, first halfword in bits 31:16.
 */
`ifndef CCCE_CONSTS_SVH
`define CCCE_CONSTS_SVH

`define CCCE_COPOP_MASK    32'hEF000010
`define CCCE_COPOP_MATCH   32'hEE000000
`define CCCE_COPOP_ALT_BIT 28
`define CCCE_XCLR_MASK     32'hFFF0D0F0
`define CCCE_XCLR_MATCH    32'hF3B08020
`define CCCE_LZCNT_MASK    32'hFFF0F0F0
`define CCCE_LZCNT_MATCH   32'hFAB0F080
`define CCCE_CNEG_MASK     32'hFBF08F00
`define CCCE_CNEG_MATCH    32'hF1100F00

`define CCCE_CP_LSB        8
`define CCCE_OPFIRST_LSB   20
`define CCCE_OPSECOND_LSB  5
`define CCCE_CRN_LSB       16
`define CCCE_CRD_LSB       12
`define CCCE_CRM_LSB       0
`define CCCE_SRC_LSB       16
`define CCCE_SRC2_LSB      0
`define CCCE_RD_LSB        8
`define CCCE_OPND_LSB      16
`define CCCE_IMM8_LSB      0
`define CCCE_IMM3_LSB      12
`define CCCE_IBIT          26

`define CCCE_REG_SP        4'hD
`define CCCE_REG_PC        4'hF
`define CCCE_FLAGS_RST     4'h0
`define CCCE_COP_TIMEOUT   8
`define CCCE_ZERO_COUNT    6'h20

`endif

// >>> ccce_pkg.sv
/*
 * Types used by the execute block only; the coprocessor does not use them.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package ccce_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_COP  = 2'b10
    } ccce_state_t;

    typedef struct packed {
        logic n;
        logic z;
        logic c;
        logic v;
    } ccce_flags_t;

endpackage

// >>> ccce_cop_if.sv
/*
 * Offer and answer handshake between the core and one coprocessor.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps

interface ccce_cop_if;
    logic        req;
    logic [31:0] instr;
    logic [3:0]  cp_num;
    logic        alt;
    logic        ack;
    logic        accept;

    modport core (output req, output instr, output cp_num, output alt,
                  input ack, input accept);
    modport cop  (input req, input instr, input cp_num, input alt,
                  output ack, output accept);
endinterface

// >>> ccce_cop.sv
/*
 * Coprocessor end: answers offers for its own number, runs internal ops
 * on a private register bank.
 * Assumes the core holds req steady until it sees ack.
 */
`timescale 1ns/1ps
`include "ccce_consts.svh"

module ccce_cop #(
    parameter logic [3:0] CP_ID = 4'h0
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_ce,
    ccce_cop_if.cop          bus,
    input  wire logic        i_wr_en,
    input  wire logic [3:0]  i_wr_index,
    input  wire logic [31:0] i_wr_data,
    input  wire logic [3:0]  i_rd_index,
    output logic [31:0]      o_rd_data
);

    logic [31:0] bank [16];
    logic        respond;
    logic        op_ok;
    logic [3:0]  first_cop_opcode;
    logic [2:0]  second_cop_opcode;
    logic [31:0] op_a;
    logic [31:0] op_b;
    logic [31:0] next_result;

    assign respond = bus.req && !bus.ack && (bus.cp_num == CP_ID);
    assign first_cop_opcode  = bus.instr[`CCCE_OPFIRST_LSB +: 4];
    assign second_cop_opcode = bus.instr[`CCCE_OPSECOND_LSB +: 3];
    assign op_a = bank[bus.instr[`CCCE_CRN_LSB +: 4]];
    assign op_b = bank[bus.instr[`CCCE_CRM_LSB +: 4]];
    assign op_ok = !first_cop_opcode[3];

    // operation chosen by first opcode, offset by second opcode
    always_comb begin
        unique case (first_cop_opcode[2:0])
            3'h0:    next_result = op_a + op_b;
            3'h1:    next_result = op_a - op_b;
            3'h2:    next_result = op_a & op_b;
            3'h3:    next_result = op_a | op_b;
            3'h4:    next_result = op_a ^ op_b;
            3'h5:    next_result = op_a;
            3'h6:    next_result = ~op_a;
            default: next_result = 32'h0000_0000;
        endcase
        next_result = next_result
            + {29'h0000_0000, second_cop_opcode};
    end

    // answer one cycle after the offer
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            bus.ack    <= 1'b0;
            bus.accept <= 1'b0;
        end else if (i_ce) begin
            bus.ack    <= respond;
            bus.accept <= respond && op_ok;
        end
    end

    // internal operation only, no core state touched
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            for (int k = 0; k < 16; k++) begin
                bank[k] <= 32'h0000_0000;
            end
        end else if (i_ce) begin
            if (respond && op_ok) begin
                bank[bus.instr[`CCCE_CRD_LSB +: 4]] <= next_result;
            end else if (i_wr_en) begin
                bank[i_wr_index] <= i_wr_data;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rd_data <= 32'h0000_0000;
        end else if (i_ce) begin
            o_rd_data <= bank[i_rd_index];
        end
    end

endmodule // ccce_cop

// >>> ccce_chk.sv
/*
 * Checker for the core to coprocessor handshake.
 * Assumes one clock and an asynchronous active-high reset.
 */
`timescale 1ns/1ps

module ccce_chk #(
    parameter int         COP_TIMEOUT = 8,
    parameter logic [3:0] CP_ID       = 4'h0
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        req,
    input  wire logic [31:0] instr,
    input  wire logic [3:0]  cp_num,
    input  wire logic        alt,
    input  wire logic        ack,
    input  wire logic        accept
);
    logic [7:0] req_run;
    // run length at the edge where the core gives up waiting
    localparam logic [7:0] LAST = 8'(COP_TIMEOUT - 1);

    // length of the current offer
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            req_run <= 8'h00;
        end else if (req) begin
            req_run <= req_run + 8'h01;
        end else begin
            req_run <= 8'h00;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    property p_num; req |-> cp_num == instr[11:8]; endproperty
    a_num: assert property (p_num)
        else $error("cp_num differs from instr field");
    property p_alt; req |-> alt == instr[28]; endproperty
    a_alt: assert property (p_alt)
        else $error("alt differs from instr bit");
    property p_form; req |-> (instr & 32'hEF000010) == 32'hEE000000;
    endproperty
    a_form: assert property (p_form)
        else $error("offer of a word that is no coprocessor op");
    property p_own; $rose(req) && cp_num == CP_ID |=> ack; endproperty
    a_own: assert property (p_own)
        else $error("own coprocessor did not answer");
    property p_other; req && cp_num != CP_ID |-> !ack; endproperty
    a_other: assert property (p_other)
        else $error("answer for a foreign number");
    property p_end; ack |=> !ack && !req; endproperty
    a_end: assert property (p_end)
        else $error("offer or answer outlives the answer");
    property p_acc; ack |-> accept == !instr[23]; endproperty
    a_acc: assert property (p_acc)
        else $error("accept does not follow opcode range");
    property p_hold; req && !ack && req_run < LAST |=> req && $stable(instr);
    endproperty
    a_hold: assert property (p_hold)
        else $error("offer dropped or changed before answer");
    property p_wait; req_run <= COP_TIMEOUT[7:0]; endproperty
    a_wait: assert property (p_wait)
        else $error("offer longer than wait limit");
endmodule // ccce_chk

// >>> coproc_clear_exclusive_instr_clz_cmn_exec_bench.sv
/*
 * Bench: core and coprocessor joined by the handshake interface.
 * Assumes 50 MHz clock, coprocessor number 0, short wait limit.
 */
`timescale 1ns/1ps

module coproc_clear_exclusive_instr_clz_cmn_exec_bench;
    localparam int TMO = 2;
    logic        i_clk = 1'b0, i_rst = 1'b1, i_issue = 1'b0;
    logic        i_cond_pass = 1'b0, i_excl_mark = 1'b0, i_wr_en = 1'b0;
    logic        i_ce = 1'b1;
    logic [31:0] i_instr = 32'h0, i_operand = 32'h0, i_wr_data = 32'h0;
    logic [3:0]  i_wr_index = 4'h0, i_rd_index = 4'h0;
    logic        o_ready, o_done, o_wb_en, o_excl_open;
    logic        o_usage_fault_a, o_undef, wb, uf, ud, rdy;
    logic [3:0]  o_wb_index, o_flags, widx, ef;
    logic [31:0] o_wb_data, o_rd_data, wdat, rdv;
    logic [11:0] ims[6] = '{12'h001, 12'h001, 12'h1AB, 12'h2AB, 12'h3AB,
                            12'h4FF};
    logic [31:0] ops[6] = '{32'hFFFFFFFF, 32'h7FFFFFFF, 32'h0, 32'h1,
                            32'h12345678, 32'h0};
    logic [31:0] cres[8] = '{32'hC, 32'hFFFFFFFE, 32'h5, 32'h7, 32'h2,
                             32'h5, 32'hFFFFFFFA, 32'h0};
    logic [31:0] bad[3] = '{32'hFAB5F184, 32'hFAB5FD85, 32'hFABFF18F};
    int          n_errors = 0, samples_checked = 0, cyc;

    ccce_cop_if cbus();
    ccce_core #(.COP_TIMEOUT(TMO)) i_ccce_core(.i_clk, .i_rst,
        .i_ce, .i_issue, .i_instr, .i_cond_pass, .i_operand,
        .i_excl_mark, .cop(cbus), .o_ready, .o_done, .o_wb_en,
        .o_wb_index, .o_wb_data, .o_flags, .o_excl_open,
        .o_usage_fault_a, .o_undef);
    ccce_cop i_ccce_cop(.i_clk, .i_rst, .i_ce, .bus(cbus),
        .i_wr_en, .i_wr_index, .i_wr_data, .i_rd_index, .o_rd_data);
    ccce_chk #(.COP_TIMEOUT(TMO)) i_ccce_chk(.i_clk, .i_rst,
        .req(cbus.req), .instr(cbus.instr), .cp_num(cbus.cp_num),
        .alt(cbus.alt), .ack(cbus.ack), .accept(cbus.accept));

    always #10 i_clk = ~i_clk;

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", samples_checked,
                 n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // one instruction, waits for retirement
    task automatic run(input logic [31:0] ins, input logic cp,
                       input logic [31:0] op);
        @(posedge i_clk);
        i_issue <= 1'b1;
        i_instr <= ins;
        i_cond_pass <= cp;
        i_operand <= op;
        @(posedge i_clk);
        i_issue <= 1'b0;
        cyc = 1;
        #1;
        rdy = o_ready;
        while (o_done !== 1'b1 && cyc < 20) begin
            @(posedge i_clk);
            #1;
            cyc++;
        end
        if (cyc >= 20) begin
            n_errors++;
            finish_test();
        end
        wb = o_wb_en;
        widx = o_wb_index;
        wdat = o_wb_data;
        uf = o_usage_fault_a;
        ud = o_undef;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr_en <= 1'b1;
        i_wr_index <= a;
        i_wr_data <= d;
        @(posedge i_clk);
        i_wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a);
        @(posedge i_clk);
        i_rd_index <= a;
        repeat (2) @(posedge i_clk);
        #1;
        rdv = o_rd_data;
    endtask

    task automatic mark();
        @(posedge i_clk);
        i_excl_mark <= 1'b1;
        @(posedge i_clk);
        i_excl_mark <= 1'b0;
        #1;
    endtask

    function automatic logic [31:0] expand(input logic [11:0] m);
        logic [31:0] u;
        u = {24'h0, 1'b1, m[6:0]};
        if (m[11:10] != 2'b00) begin
            return (u >> m[11:7]) | (u << (6'h20 - {1'b0, m[11:7]}));
        end
        case (m[9:8])
            2'b00: return {24'h0, m[7:0]};
            2'b01: return {2{8'h00, m[7:0]}};
            2'b10: return {2{m[7:0], 8'h00}};
            default: return {4{m[7:0]}};
        endcase
    endfunction

    function automatic logic [3:0] nzcv(input logic [31:0] a,
                                        input logic [31:0] b);
        logic [32:0] s;
        s = {1'b0, a} + {1'b0, b};
        return {s[31], s[31:0] == 32'h0, s[32],
                a[31] == b[31] && s[31] != a[31]};
    endfunction

    initial begin
        repeat (10) @(posedge i_clk);
        i_rst <= 1'b0;
        // leading zero count, all-zero and edge operands
        run(32'hFAB5F185, 1'b1, 32'h0000FFFF);
        chk("wb_en", 32'h1, 32'(wb));
        chk("wb_index", 32'h1, 32'(widx));
        chk("count", 32'h10, wdat);
        run(32'hFAB5F185, 1'b1, 32'h0);
        chk("count", 32'h20, wdat);
        run(32'hFAB5F185, 1'b1, 32'h1);
        chk("count", 32'h1F, wdat);
        run(32'hFAB5F185, 1'b0, 32'h1);
        chk("wb_en", 32'h0, 32'(wb));
        for (int i = 0; i < 3; i++) begin
            run(bad[i], 1'b1, 32'h1);
            chk("undef", 32'h1, 32'(ud));
            chk("wb_en", 32'h0, 32'(wb));
        end
        $display("test count done");
        for (int i = 0; i < 6; i++) begin
            ef = nzcv(ops[i], expand(ims[i]));
            run(32'hF1100F00 | {5'h0, ims[i][11], 6'h0, 4'(i + 9), 1'b0,
                ims[i][10:8], 4'h0, ims[i][7:0]}, 1'b1, ops[i]);
            chk("flags", 32'(ef), 32'(o_flags));
            chk("undef", 32'h0, 32'(ud));
            chk("wb_en", 32'h0, 32'(wb));
        end
        run(32'hF1100F01, 1'b0, 32'hFFFFFFFF);
        chk("flags", 32'(ef), 32'(o_flags));
        run(32'hF11F0F01, 1'b1, 32'hFFFFFFFF);
        chk("undef", 32'h1, 32'(ud));
        chk("flags", 32'(ef), 32'(o_flags));
        $display("test compare done");
        mark();
        chk("excl", 32'h1, 32'(o_excl_open));
        run(32'hF3BF8F2F, 1'b0, 32'h0);
        chk("excl", 32'h1, 32'(o_excl_open));
        run(32'hF3BF8F2F, 1'b1, 32'h0);
        chk("excl", 32'h0, 32'(o_excl_open));
        mark();
        run(32'hF3B08020, 1'b1, 32'h0);
        chk("excl", 32'h0, 32'(o_excl_open));
        // clock enable low: a mark must not reach the monitor
        @(posedge i_clk);
        i_ce <= 1'b0;
        mark();
        chk("excl", 32'h0, 32'(o_excl_open));
        @(posedge i_clk);
        i_ce <= 1'b1;
        $display("test exclusive done");
        wr(4'h2, 32'h5);
        wr(4'h3, 32'h7);
        for (int k = 0; k < 8; k++) begin
            run(32'hEE024003 | (k << 20), 1'b1, 32'h0);
            chk("fault", 32'h0, 32'(uf));
            chk("cycles", 32'h3, 32'(cyc));
            chk("ready", 32'h0, 32'(rdy));
            rd(4'h4);
            chk("cop result", cres[k], rdv);
        end
        run(32'hFE021023, 1'b1, 32'h0);
        rd(4'h1);
        chk("cop result", 32'hD, rdv);
        run(32'hEE821003, 1'b1, 32'h0);
        chk("fault", 32'h1, 32'(uf));
        rd(4'h1);
        chk("cop result", 32'hD, rdv);
        run(32'hEE021303, 1'b1, 32'h0);
        chk("fault", 32'h1, 32'(uf));
        chk("cycles", 32'(TMO + 1), 32'(cyc));
        run(32'hEE021003, 1'b0, 32'h0);
        chk("fault", 32'h0, 32'(uf));
        chk("cycles", 32'h1, 32'(cyc));
        rd(4'h1);
        chk("cop result", 32'hD, rdv);
        run(32'hEE021013, 1'b1, 32'h0);
        chk("undef", 32'h1, 32'(ud));
        $display("test coprocessor done");
        finish_test();
    end
endmodule // coproc_clear_exclusive_instr_clz_cmn_exec_bench
